// >>> inc/tlp_err_pkg.sv
/*
 * Shared constants and carriers for the receive-side error arbiter.
 * Assumes one 10 MHz core clock and an AHB-Lite register bus with 32-bit data.
 */
package tlp_err_pkg;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] UNC_OFS     = 8'h04;
   localparam logic [7:0] COR_OFS     = 8'h08;
   localparam logic [7:0] SEV_OFS     = 8'h0C;
   localparam logic [7:0] PRI_OFS     = 8'h10;
   localparam logic [7:0] SEC_OFS     = 8'h14;
   localparam logic [7:0] IRQ_ST_OFS  = 8'h18;
   localparam logic [7:0] IRQ_MSK_OFS = 8'h1C;
   localparam logic [7:0] HDR0_OFS    = 8'h20;
   localparam logic [7:0] LEVEL_OFS   = 8'h30;

   // Control bit positions.
   localparam int CTRL_DSP    = 0;
   localparam int CTRL_SV     = 1;
   localparam int CTRL_TB     = 2;
   localparam int CTRL_EGRESS = 3;
   localparam int CTRL_RDR    = 4;
   localparam int CTRL_DT     = 5;
   localparam int CTRL_W      = 6;

   // Uncorrectable status and severity bit positions.
   localparam int UNC_POIS   = 0;
   localparam int UNC_UCPL   = 1;
   localparam int UNC_UR     = 2;
   localparam int UNC_MCBLK  = 3;
   localparam int UNC_ACS    = 4;
   localparam int UNC_MALF   = 5;
   localparam int UNC_ECRC   = 6;
   localparam int UNC_OVF    = 7;
   localparam int UNC_INTERN = 8;
   localparam int UNC_OTHER  = 9;
   localparam int UNC_W      = 10;

   // Correctable status, status-register and interrupt bit positions.
   localparam int COR_ADV    = 0;
   localparam int STS_PARITY = 0;
   localparam int STS_STA    = 1;
   localparam int IRQ_UNC    = 0;
   localparam int IRQ_COR    = 1;
   localparam int IRQ_PARITY = 2;
   localparam int IRQ_STA    = 3;
   localparam int IRQ_W      = 4;

   // Reset values.
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [UNC_W-1:0]  SEV_RST  = 10'h3F0;
   localparam logic [IRQ_W-1:0]  MSK_RST  = 4'h0;

   // Priority levels of receive errors, highest first.
   localparam logic [2:0] LVL_OVF   = 3'h7;
   localparam logic [2:0] LVL_ECRC  = 3'h6;
   localparam logic [2:0] LVL_MALF  = 3'h5;
   localparam logic [2:0] LVL_ACS   = 3'h4;
   localparam logic [2:0] LVL_MCBLK = 3'h3;
   localparam logic [2:0] LVL_URUC  = 3'h2;
   localparam logic [2:0] LVL_POIS  = 3'h1;
   localparam logic [2:0] LVL_NONE  = 3'h0;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // One received TLP with the checker results of the neighbouring stages.
   typedef struct packed {
      logic         valid;
      logic         overflow;
      logic         ecrc_err;
      logic         ult_receiver;
      logic         malformed;
      logic         mc_blocked;
      logic         unsup_req;
      logic         unexp_cpl;
      logic         poisoned;
      logic         internal_err;
      logic         non_posted;
      logic         local_or_gathered_msg;
      logic         secondary_side;
      logic         sv_fail;
      logic         tb_fail;
      logic         egress_fail;
      logic         redirect_hit;
      logic         direct_translated;
      logic [127:0] header;
   } rx_tlp_s;

   // Verdict returned to the datapath one cycle after the TLP.
   typedef struct packed {
      logic       valid;
      logic       drop;
      logic       ca_cpl;
      logic       redirect;
      logic [2:0] level;
   } verdict_s;

endpackage

// >>> design/tlp_error_priority_acs.sv
/*
 * Receive error arbiter of one switch port: ACS violation handling, error
 * priority for AER logging, status flags and an AHB-Lite register slave.
 * Assumes the checker results of one TLP arrive in one cycle on hclk and that
 * the datapath acts on the registered verdict one cycle later.
 */
// Operation
// - ACS checks only in downstream switch port mode; detecting function logs.
// - ACS redirection is normal; nothing is recorded in AER.
// - ACS blocking is an ACS violation, logged in AER.
// - No source validation on local-terminate or gathered-to-root messages.
// - Non-posted violation returns completer abort, not counted as completer abort.
// - Non-posted violation sets signaled target abort in secondary status.
// - Non-posted violation with nonfatal severity is advisory correctable; others uncorrectable.
// - Every violation captures the header log and drops the TLP.
// - Translation blocking and egress violations classify like source validation.
// - Direct translated TLPs follow egress control and redirect rules.
// - Only reception errors are prioritised; others log every time.
// - Internal errors bypass priority; several errors may log per TLP.
// - Poisoned TLP always sets detected parity error on its side.
// - Ranking: overflow 7, ECRC, malformed, ACS 4, multicast, UR and unexpected sharing 2, poisoned 1.
// - Only the highest priority error of a TLP is logged.
// - Lower errors still checked and handled unless the TLP was dropped.
// - Overflow only checked and logged; ECRC checked after passing overflow.
// - ECRC TLP blocked by ACS: blocked, not logged, no completer abort.
`timescale 1ns/10ps
module tlp_error_priority_acs (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire tlp_err_pkg::rx_tlp_s  rx_tlp,
   input  wire logic                  other_err,
   output tlp_err_pkg::verdict_s      verdict,
   output logic                       irq
);

   // Write-one-to-clear update where a new event beats the clear.
   function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] clr,
                                       input logic [31:0] set);
      w1c = (cur & ~clr) | set;
   endfunction

   localparam int UW = tlp_err_pkg::UNC_W;
   localparam int IW = tlp_err_pkg::IRQ_W;

   logic [tlp_err_pkg::CTRL_W-1:0] ctrl_q;
   logic [UW-1:0]                  unc_q;
   logic                           cor_q;
   logic [UW-1:0]                  uncorrectable_error_severity_reg_q;
   logic                           primary_status_reg_q;
   logic [1:0]                     secondary_status_reg_q;
   logic [IW-1:0]                  irq_st_q;
   logic [IW-1:0]                  irq_msk_q;
   logic [127:0]                   hdr_q;
   logic [2:0]                     level_q;
   tlp_err_pkg::verdict_s          verdict_q;
   logic                           irq_q;
   logic                           hreadyout_q;
   logic                           hresp_q;
   logic [31:0]                    hrdata_q;
   logic                           wr_pend_q;
   logic [7:0]                     wr_addr_q;

   // ACS checks, armed only on a downstream switch port.
   wire acs_on    = ctrl_q[tlp_err_pkg::CTRL_DSP];
   wire sv_blk    = ctrl_q[tlp_err_pkg::CTRL_SV] & rx_tlp.sv_fail
                    & ~rx_tlp.local_or_gathered_msg;
   wire tb_blk    = ctrl_q[tlp_err_pkg::CTRL_TB] & rx_tlp.tb_fail;
   // A direct translated TLP is judged by the egress and redirect controls.
   wire p2p_ok    = ~rx_tlp.direct_translated | ctrl_q[tlp_err_pkg::CTRL_DT];
   wire eg_blk    = ctrl_q[tlp_err_pkg::CTRL_EGRESS] & rx_tlp.egress_fail & p2p_ok;
   wire acs_blk   = acs_on & (sv_blk | tb_blk | eg_blk);
   wire acs_rdr   = acs_on & ctrl_q[tlp_err_pkg::CTRL_RDR] & rx_tlp.redirect_hit
                    & p2p_ok & ~acs_blk;

   // Survival chain: a check runs only while the TLP is still alive.
   wire v         = rx_tlp.valid;
   wire e_ovf     = v & rx_tlp.overflow;
   wire alive7    = v & ~rx_tlp.overflow;
   wire e_ecrc    = alive7 & rx_tlp.ecrc_err;
   wire alive6    = alive7 & ~(rx_tlp.ecrc_err & rx_tlp.ult_receiver);
   wire e_malf    = alive6 & rx_tlp.malformed;
   wire alive5    = alive6 & ~rx_tlp.malformed;
   wire e_acs     = alive5 & acs_blk;
   wire alive4    = alive5 & ~acs_blk;
   wire e_mc      = alive4 & rx_tlp.mc_blocked;
   wire alive3    = alive4 & ~rx_tlp.mc_blocked;
   // Unsupported request and unexpected completion never coincide.
   wire e_uruc    = alive3 & (rx_tlp.unsup_req | rx_tlp.unexp_cpl);
   wire alive2    = alive3 & ~(rx_tlp.unsup_req | rx_tlp.unexp_cpl);
   wire e_pois    = alive2 & rx_tlp.poisoned;

   // Priority encoder over the surviving errors.
   wire [2:0] lvl = e_ovf  ? tlp_err_pkg::LVL_OVF   :
                    e_ecrc ? tlp_err_pkg::LVL_ECRC  :
                    e_malf ? tlp_err_pkg::LVL_MALF  :
                    e_acs  ? tlp_err_pkg::LVL_ACS   :
                    e_mc   ? tlp_err_pkg::LVL_MCBLK :
                    e_uruc ? tlp_err_pkg::LVL_URUC  :
                    e_pois ? tlp_err_pkg::LVL_POIS  : tlp_err_pkg::LVL_NONE;

   // Only the winning level is logged; lower ones set no AER bit, though a lower poisoned TLP still sets its parity flag.
   wire lg_acs    = (lvl == tlp_err_pkg::LVL_ACS);
   wire sev_fatal = uncorrectable_error_severity_reg_q[tlp_err_pkg::UNC_ACS];
   wire acs_adv   = lg_acs & rx_tlp.non_posted & ~sev_fatal;
   wire acs_unc   = lg_acs & ~acs_adv;
   wire ca_cpl    = lg_acs & rx_tlp.non_posted;

   // Per-bit uncorrectable set vector, one-hot for the ranked errors.
   logic [UW-1:0] unc_set;
   always_comb begin
      unc_set = '0;
      unc_set[tlp_err_pkg::UNC_OVF]    = (lvl == tlp_err_pkg::LVL_OVF);
      unc_set[tlp_err_pkg::UNC_ECRC]   = (lvl == tlp_err_pkg::LVL_ECRC);
      unc_set[tlp_err_pkg::UNC_MALF]   = (lvl == tlp_err_pkg::LVL_MALF);
      unc_set[tlp_err_pkg::UNC_ACS]    = acs_unc;
      unc_set[tlp_err_pkg::UNC_MCBLK]  = (lvl == tlp_err_pkg::LVL_MCBLK);
      unc_set[tlp_err_pkg::UNC_UR]     = (lvl == tlp_err_pkg::LVL_URUC) & rx_tlp.unsup_req;
      unc_set[tlp_err_pkg::UNC_UCPL]   = (lvl == tlp_err_pkg::LVL_URUC) & ~rx_tlp.unsup_req;
      unc_set[tlp_err_pkg::UNC_POIS]   = (lvl == tlp_err_pkg::LVL_POIS);
      unc_set[tlp_err_pkg::UNC_INTERN] = v & rx_tlp.internal_err;
      unc_set[tlp_err_pkg::UNC_OTHER]  = other_err;
   end

   // Parity flags ignore priority and suppression; target abort follows only a winning non-posted ACS error.
   wire pois_rx   = v & rx_tlp.poisoned;
   wire dpe_pri   = pois_rx & ~rx_tlp.secondary_side;
   wire dpe_sec   = pois_rx & rx_tlp.secondary_side;
   wire sta_set   = ca_cpl;
   wire hdr_cap   = (lvl != tlp_err_pkg::LVL_NONE);
   wire drop      = v & ~alive2;

   wire [IW-1:0] irq_set = {sta_set, dpe_pri | dpe_sec, acs_adv,
                            |unc_set};

   // Bus decode: a selected NONSEQ transfer in the address phase; hsize is not decoded.
   wire        acc     = hsel & hready & (htrans == tlp_err_pkg::HTRANS_NONSEQ);
   wire        rd_acc  = acc & ~hwrite;
   wire [7:0]  ofs     = {haddr[7:2], 2'b00};
   wire        wr_hit  = wr_pend_q;
   wire [31:0] wd      = hwdata;
   wire        wr_ctrl = wr_hit & (wr_addr_q == tlp_err_pkg::CTRL_OFS);
   wire        wr_unc  = wr_hit & (wr_addr_q == tlp_err_pkg::UNC_OFS);
   wire        wr_cor  = wr_hit & (wr_addr_q == tlp_err_pkg::COR_OFS);
   wire        wr_sev  = wr_hit & (wr_addr_q == tlp_err_pkg::SEV_OFS);
   wire        wr_pri  = wr_hit & (wr_addr_q == tlp_err_pkg::PRI_OFS);
   wire        wr_sec  = wr_hit & (wr_addr_q == tlp_err_pkg::SEC_OFS);
   wire        wr_ist  = wr_hit & (wr_addr_q == tlp_err_pkg::IRQ_ST_OFS);
   wire        wr_msk  = wr_hit & (wr_addr_q == tlp_err_pkg::IRQ_MSK_OFS);

   // Read multiplexer; unmapped offsets read as zero.
   logic [31:0] rd_mux;
   always_comb begin
      case (ofs)
         tlp_err_pkg::CTRL_OFS:    rd_mux = {26'h0, ctrl_q};
         tlp_err_pkg::UNC_OFS:     rd_mux = {22'h0, unc_q};
         tlp_err_pkg::COR_OFS:     rd_mux = {31'h0, cor_q};
         tlp_err_pkg::SEV_OFS:     rd_mux = {22'h0, uncorrectable_error_severity_reg_q};
         tlp_err_pkg::PRI_OFS:     rd_mux = {31'h0, primary_status_reg_q};
         tlp_err_pkg::SEC_OFS:     rd_mux = {30'h0, secondary_status_reg_q};
         tlp_err_pkg::IRQ_ST_OFS:  rd_mux = {28'h0, irq_st_q};
         tlp_err_pkg::IRQ_MSK_OFS: rd_mux = {28'h0, irq_msk_q};
         tlp_err_pkg::HDR0_OFS:         rd_mux = hdr_q[31:0];
         tlp_err_pkg::HDR0_OFS + 8'h04: rd_mux = hdr_q[63:32];
         tlp_err_pkg::HDR0_OFS + 8'h08: rd_mux = hdr_q[95:64];
         tlp_err_pkg::HDR0_OFS + 8'h0C: rd_mux = hdr_q[127:96];
         tlp_err_pkg::LEVEL_OFS:   rd_mux = {29'h0, level_q};
         default:                  rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus slave: zero wait states, so a write lands in its data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b0;
         hresp_q     <= 1'b0;
         hrdata_q    <= 32'h0000_0000;
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
      end else begin
         hreadyout_q <= 1'b1;
         wr_pend_q   <= acc & hwrite;
         wr_addr_q   <= ofs;
         if (rd_acc) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // Software-owned configuration.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q                             <= tlp_err_pkg::CTRL_RST;
         uncorrectable_error_severity_reg_q <= tlp_err_pkg::SEV_RST;
         irq_msk_q                          <= tlp_err_pkg::MSK_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= wd[tlp_err_pkg::CTRL_W-1:0];
         if (wr_sev) uncorrectable_error_severity_reg_q <= wd[UW-1:0];
         if (wr_msk) irq_msk_q <= wd[IW-1:0];
      end
   end

   // Sticky AER and status flags; an event in the clearing cycle survives.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unc_q                  <= '0;
         cor_q                  <= 1'b0;
         primary_status_reg_q   <= 1'b0;
         secondary_status_reg_q <= 2'b00;
         irq_st_q               <= '0;
      end else begin
         unc_q    <= UW'(w1c(32'(unc_q), wr_unc ? wd : 32'h0, 32'(unc_set)));
         cor_q    <= (cor_q & ~(wr_cor & wd[tlp_err_pkg::COR_ADV])) | acs_adv;
         primary_status_reg_q <= (primary_status_reg_q & ~(wr_pri & wd[tlp_err_pkg::STS_PARITY]))
                                 | dpe_pri;
         secondary_status_reg_q <= 2'(w1c(32'(secondary_status_reg_q), wr_sec ? wd : 32'h0,
                                          32'({sta_set, dpe_sec})));
         irq_st_q <= IW'(w1c(32'(irq_st_q), wr_ist ? wd : 32'h0, 32'(irq_set)));
      end
   end

   // Header log and last winning level follow each TLP with a winning ranked error; an internal error alone captures neither.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hdr_q   <= '0;
         level_q <= tlp_err_pkg::LVL_NONE;
      end else if (hdr_cap) begin
         hdr_q   <= rx_tlp.header;
         level_q <= lvl;
      end
   end

   // Verdict to the datapath and the level interrupt.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         verdict_q <= '0;
         irq_q     <= 1'b0;
      end else begin
         verdict_q.valid    <= v;
         verdict_q.drop     <= drop;
         verdict_q.ca_cpl   <= ca_cpl;
         verdict_q.redirect <= alive5 & acs_rdr;
         verdict_q.level    <= lvl;
         irq_q              <= |(irq_st_q & irq_msk_q);
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;
   assign hrdata    = hrdata_q;
   assign verdict   = verdict_q;
   assign irq       = irq_q;

endmodule // tlp_error_priority_acs

// >>> dv/tlp_err_properties.sv
/* Concurrent checks on the verdict and bus response of the receive error arbiter.
   Assumes it is bound to the top module and sees only that module's ports. */
`timescale 1ns/10ps
module tlp_err_properties (
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire tlp_err_pkg::rx_tlp_s  rx_tlp,
   input wire tlp_err_pkg::verdict_s verdict
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Summaries of the flag groups, so each property names its own cause only.
   wire logic t_up  = rx_tlp.valid && !rx_tlp.overflow && !rx_tlp.ecrc_err;
   wire logic low_e = rx_tlp.mc_blocked || rx_tlp.unsup_req || rx_tlp.unexp_cpl;
   wire logic acs_e = rx_tlp.sv_fail || rx_tlp.tb_fail || rx_tlp.egress_fail;
   a_verdict_follows: assert property (rx_tlp.valid |=> verdict.valid)
      else $error("verdict missing one cycle after a TLP");
   a_verdict_alone: assert property (!rx_tlp.valid |=> !verdict.valid)
      else $error("verdict without a TLP");
   a_overflow_wins: assert property (rx_tlp.valid && rx_tlp.overflow |=>
      verdict.level == tlp_err_pkg::LVL_OVF && verdict.drop) else $error("overflow not top level");
   a_ecrc_second: assert property (rx_tlp.valid && !rx_tlp.overflow && rx_tlp.ecrc_err |=>
      verdict.level == tlp_err_pkg::LVL_ECRC && !verdict.ca_cpl && (verdict.drop || !$past(rx_tlp.ult_receiver)))
      else $error("ECRC level or handling wrong");
   a_malformed_third: assert property (t_up && rx_tlp.malformed |=>
      verdict.level == tlp_err_pkg::LVL_MALF && verdict.drop) else $error("malformed level wrong");
   a_ur_shared: assert property (t_up && !rx_tlp.malformed && !acs_e && !rx_tlp.mc_blocked &&
      (rx_tlp.unsup_req || rx_tlp.unexp_cpl) |=> verdict.level == tlp_err_pkg::LVL_URUC)
      else $error("UR or unexpected completion level wrong");
   a_poison_last: assert property (t_up && !rx_tlp.malformed && !acs_e && !low_e && rx_tlp.poisoned |=>
      verdict.level == tlp_err_pkg::LVL_POIS && !verdict.drop) else $error("poisoned TLP handled wrong");
   a_clean_tlp: assert property (t_up && !rx_tlp.malformed && !acs_e && !low_e && !rx_tlp.poisoned |=>
      verdict.level == tlp_err_pkg::LVL_NONE && !verdict.drop && !verdict.ca_cpl) else $error("clean TLP flagged");
   a_abort_is_acs: assert property (verdict.valid && verdict.ca_cpl |->
      verdict.level == tlp_err_pkg::LVL_ACS && verdict.drop) else $error("abort without winning ACS error");
   a_bus_okay: assert property ($past(hresetn) |-> hreadyout && !hresp)
      else $error("bus slave not ready or not OKAY");
endmodule // tlp_err_properties

// >>> dv/tlp_link_model.sv
/* Behavioural link partner that hands one received TLP at a time to the arbiter.
   Assumes send is entered just after a rising clock edge. */
`timescale 1ns/10ps
module tlp_link_model (
   input  wire logic            hclk,
   output tlp_err_pkg::rx_tlp_s rx_tlp
);
   // No TLP at start; the header is never left holding a stale value.
   initial rx_tlp = '0;
   // One TLP for one clock, then idle with a flipped header so stale data never looks valid.
   task automatic send(input tlp_err_pkg::rx_tlp_s t);
      t.valid = 1'b1;
      rx_tlp <= t;
      @(posedge hclk);
      rx_tlp <= '{header: ~t.header, default: 1'b0};
   endtask
endmodule // tlp_link_model

// >>> dv/tb_tlp_error_priority_acs.sv
/* Self-checking bench for the receive error arbiter: priority, ACS, status and interrupt.
   Assumes the package, the design, the link model and the property checker. */
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, a, e); end end
module tb_tlp_error_priority_acs;
   localparam logic [16:0] F_OVF = 17'h10000, F_ECRC = 17'h08000, F_ULT = 17'h04000, F_MALF = 17'h02000;
   localparam logic [16:0] F_MC = 17'h01000, F_UR = 17'h00800, F_UC = 17'h00400, F_POIS = 17'h00200;
   localparam logic [16:0] F_INT = 17'h00100, F_NP = 17'h00080, F_LOC = 17'h00040, F_SEC = 17'h00020;
   localparam logic [16:0] F_SV = 17'h00010, F_TB = 17'h00008, F_EG = 17'h00004, F_RD = 17'h00002;
   localparam logic [16:0] F_DT = 17'h00001;
   localparam logic [127:0] HDR = {4{32'hA5C3_1E0F}};
   logic                  hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, other_err = 1'b0;
   logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]            htrans = 2'h0;
   logic [2:0]            hsize = tlp_err_pkg::HSIZE_WORD;
   logic                  hreadyout, hresp, irq;
   tlp_err_pkg::rx_tlp_s  rx_tlp;
   tlp_err_pkg::verdict_s verdict;
   int                    miscompares = 0, n_checks = 0;
   // A 100 ns clock.
   always #50 hclk = ~hclk;
   tlp_error_priority_acs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rx_tlp(rx_tlp), .other_err(other_err), .verdict(verdict), .irq(irq));
   tlp_link_model link_u (.hclk(hclk), .rx_tlp(rx_tlp));
   // The single exit of the run.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Bounded wait for an edge with hready high; a hung slave ends the run.
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // One AHB-Lite single word transfer; read data is taken at the data phase's ready edge.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= tlp_err_pkg::HTRANS_NONSEQ;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      `CHK(r, e)
   endtask
   // Sends one TLP and judges the verdict mid-cycle; dcr holds drop, completer abort, redirect.
   task automatic tlp(input logic [16:0] f, input logic [2:0] lv, input logic [2:0] dcr);
      link_u.send({1'b1, f, HDR});
      @(negedge hclk);
      `CHK({verdict.valid, verdict.level}, {1'b1, lv})
      `CHK({verdict.drop, verdict.ca_cpl, verdict.redirect}, dcr)
      @(posedge hclk);
   endtask
   // Clears every sticky bit, the log before the interrupt summary, so each case starts clean.
   task automatic clr;
      wr(tlp_err_pkg::UNC_OFS, 32'h3FF);
      wr(tlp_err_pkg::COR_OFS, 32'h1);
      wr(tlp_err_pkg::PRI_OFS, 32'h1);
      wr(tlp_err_pkg::SEC_OFS, 32'h3);
      wr(tlp_err_pkg::IRQ_ST_OFS, 32'hF);
   endtask
   task automatic t_regs;
      rd(tlp_err_pkg::CTRL_OFS, 32'h0);
      rd(tlp_err_pkg::SEV_OFS, 32'h3F0);
      wr(tlp_err_pkg::LEVEL_OFS, 32'h7);
      wr(8'h3C, 32'hFFFF_FFFF);
      rd(tlp_err_pkg::LEVEL_OFS, 32'h0);
      rd(8'h3C, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_prio;
      logic [16:0] f [7] = '{F_OVF | F_ECRC | F_MALF, F_ECRC | F_ULT | F_MALF, F_MALF | F_MC | F_POIS,
                             F_MC | F_UR, F_UC | F_POIS, F_ECRC | F_UR, F_POIS | F_SEC};
      logic [2:0]  lv [7] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h6, 3'h1};
      logic [2:0]  dc [7] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0};
      logic [9:0]  un [7] = '{10'h080, 10'h040, 10'h020, 10'h008, 10'h002, 10'h040, 10'h001};
      logic [1:0]  ps [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2};
      for (int i = 0; i < 7; i++) begin
         tlp(f[i], lv[i], dc[i]);
         rd(tlp_err_pkg::UNC_OFS, {22'h0, un[i]});
         rd(tlp_err_pkg::PRI_OFS, {31'h0, ps[i][0]});
         rd(tlp_err_pkg::SEC_OFS, {31'h0, ps[i][1]});
         rd(tlp_err_pkg::LEVEL_OFS, {29'h0, lv[i]});
         clr();
      end
      $display("test priority done");
   endtask
   task automatic t_acs;
      tlp(F_SV | F_NP, 3'h0, 3'h0);
      rd(tlp_err_pkg::UNC_OFS, 32'h0);
      wr(tlp_err_pkg::CTRL_OFS, 32'h0F);
      tlp(F_SV | F_NP, 3'h4, 3'h6);
      rd(tlp_err_pkg::UNC_OFS, 32'h010);
      rd(tlp_err_pkg::SEC_OFS, 32'h2);
      rd(tlp_err_pkg::HDR0_OFS, HDR[31:0]);
      clr();
      wr(tlp_err_pkg::SEV_OFS, 32'h3E0);
      tlp(F_TB | F_NP, 3'h4, 3'h6);
      rd(tlp_err_pkg::COR_OFS, 32'h1);
      rd(tlp_err_pkg::UNC_OFS, 32'h0);
      rd(tlp_err_pkg::IRQ_ST_OFS, 32'hA);
      clr();
      tlp(F_EG, 3'h4, 3'h4);
      rd(tlp_err_pkg::UNC_OFS, 32'h010);
      rd(tlp_err_pkg::SEC_OFS, 32'h0);
      clr();
      tlp(F_SV | F_LOC, 3'h0, 3'h0);
      tlp(F_ECRC | F_SV | F_NP, 3'h6, 3'h4);
      rd(tlp_err_pkg::SEC_OFS, 32'h0);
      rd(tlp_err_pkg::UNC_OFS, 32'h040);
      clr();
      wr(tlp_err_pkg::CTRL_OFS, 32'h1F);
      tlp(F_DT | F_EG, 3'h0, 3'h0);
      tlp(F_RD, 3'h0, 3'h1);
      rd(tlp_err_pkg::UNC_OFS, 32'h0);
      wr(tlp_err_pkg::CTRL_OFS, 32'h3F);
      tlp(F_DT | F_EG | F_NP, 3'h4, 3'h6);
      rd(tlp_err_pkg::COR_OFS, 32'h1);
      clr();
      $display("test acs done");
   endtask
   task automatic t_misc;
      tlp(F_INT | F_POIS, 3'h1, 3'h0);
      rd(tlp_err_pkg::UNC_OFS, 32'h101);
      clr();
      other_err <= 1'b1;
      repeat (2) @(posedge hclk);
      other_err <= 1'b0;
      rd(tlp_err_pkg::UNC_OFS, 32'h200);
      @(negedge hclk);
      `CHK(irq, 1'b0)
      @(posedge hclk);
      wr(tlp_err_pkg::IRQ_MSK_OFS, 32'h1);
      repeat (2) @(negedge hclk);
      `CHK(irq, 1'b1)
      @(posedge hclk);
      rd(tlp_err_pkg::IRQ_ST_OFS, 32'h1);
      clr();
      repeat (2) @(negedge hclk);
      `CHK(irq, 1'b0)
      @(posedge hclk);
      $display("test misc done");
   endtask
   // A reset in mid-run must bring back the configuration and clear the level log.
   task automatic t_reset;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(tlp_err_pkg::CTRL_OFS, 32'h0);
      rd(tlp_err_pkg::SEV_OFS, 32'h3F0);
      rd(tlp_err_pkg::LEVEL_OFS, 32'h0);
      $display("test reset done");
   endtask
   // Reset for 16 cycles, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_prio();
      t_acs();
      t_misc();
      t_reset();
      report_and_stop();
   end
endmodule // tb_tlp_error_priority_acs
bind tlp_error_priority_acs tlp_err_properties chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .rx_tlp(rx_tlp), .verdict(verdict));
